// [hdl/adc_port.sv]
// Purpose: serial port pin logic, logic outputs, clock gate and power-on
//          hold of a multi-channel converter, with an AXI4-Lite slave
// Assumes: serial and crystal pins asynchronous to MCLK, bus pins synchronous; MCLK far faster than SCLK
// Notes:   CE low freezes every flip-flop
//
// How it works
// - SCLK edges count only while CS_B is low, never while high.
// - the serial output is released whenever CS_B is high.
// - one input bit is taken per SCLK period while selected.
// - the two logic outputs follow setup bits 22 and 23.
// - the master clock comes from the crystal gate or an outside clock.
// - with the polarity bit at 1 the word is sent as plain binary.
// - with the polarity bit at 0 the word is sent two's complement.
// - after power-up the port is held for 2006 oscillator cycles.
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`include "adc_port_cfg.svh"
module adc_port #(
   parameter int WORD_BITS = 24
) (
   input  wire logic        MCLK,
   input  wire logic        RST_B,
   input  wire logic        CE,
   input  wire logic [7:0]  AWADDR,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   output logic [1:0]       BRESP,
   output logic             BVALID,
   input  wire logic        BREADY,
   input  wire logic [7:0]  ARADDR,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   output logic             RVALID,
   input  wire logic        RREADY,
   input  wire logic        CS_B,
   input  wire logic        SCLK,
   input  wire logic        SERIAL_IN_PIN,
   output logic             SERIAL_OUT_PIN,
   output logic             SERIAL_OUT_OE_B,
   output logic             LOGIC_OUT_LOW,
   output logic             LOGIC_OUT_HIGH,
   input  wire logic        CRYSTAL_INPUT,
   output logic             CRYSTAL_OUTPUT
);
   localparam int CW = $clog2(WORD_BITS + 1);

   // ------------------------------------------------------------------
   // pin synchronisers and edges
   // ------------------------------------------------------------------
   logic [3:0]    pins_q;
   logic          sclk_prev_ff;
   logic          cs_prev_ff;
   logic          xin_prev_ff;

   pin_sync #(.W(4), .INIT(4'h8)) u_sync (
      .clk   (MCLK),
      .rst_b (RST_B),
      .ce    (CE),
      .d     ({CS_B, SCLK, SERIAL_IN_PIN, CRYSTAL_INPUT}),
      .q     (pins_q)
   );

   wire cs_q       = pins_q[3];
   wire sclk_q     = pins_q[2];
   wire sdi_q      = pins_q[1];
   wire xin_q      = pins_q[0];
   wire sclk_rise  = sclk_q & ~sclk_prev_ff;
   wire sclk_fall  = ~sclk_q & sclk_prev_ff;
   wire cs_fall    = ~cs_q & cs_prev_ff;
   wire xin_rise   = xin_q & ~xin_prev_ff;

   // ------------------------------------------------------------------
   // power-on hold
   // ------------------------------------------------------------------
   adc_port_pkg::por_state_t state_ff;
   logic [10:0]   por_cnt_ff;
   wire por_busy  = (state_ff == adc_port_pkg::ST_POR_WAIT);
   wire por_last  = xin_rise & (por_cnt_ff == `CFG_POR_OSC_CYCLES - 11'h1);
   // selection counts only once the hold is over
   wire sel       = ~cs_q & ~por_busy;

   // ------------------------------------------------------------------
   // register file and bus decode
   // ------------------------------------------------------------------
   logic          gate_en_ff;
   logic          rv_ff;
   logic          rxv_ff;
   logic [31:0]   setup_ff;
   logic [31:0]   tx_raw_ff;
   logic [WORD_BITS-1:0] rx_word_ff;
   logic [7:0]    awaddr_ff;
   logic [31:0]   wdata_ff;
   logic [3:0]    wstrb_ff;

   wire [31:0] bmask   = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                          {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
   wire do_write       = ~AWREADY & ~WREADY & ~BVALID;
   wire wr_ctrl        = do_write & (awaddr_ff == `CFG_ADDR_CTRL);
   wire wr_status      = do_write & (awaddr_ff == `CFG_ADDR_STATUS);
   wire wr_setup       = do_write & (awaddr_ff == `CFG_ADDR_SETUP);
   wire wr_tx          = do_write & (awaddr_ff == `CFG_ADDR_TX_RAW);
   wire wr_hit         = wr_ctrl | wr_status | wr_setup | wr_tx |
                         (awaddr_ff == `CFG_ADDR_RX_DATA);
   wire clr_rv         = wr_status & wstrb_ff[0] & wdata_ff[`CFG_ST_RV_BIT];
   wire clr_rxv        = wr_status & wstrb_ff[0] & wdata_ff[`CFG_ST_RXV_BIT];
   wire [31:0] status_w = {28'h0, ~cs_q, por_busy, rxv_ff, rv_ff};
   wire [31:0] rx_w     = {{(32-WORD_BITS){1'b0}}, rx_word_ff};
   wire ar_take        = ARVALID & ARREADY;
   wire rd_ctrl        = (ARADDR == `CFG_ADDR_CTRL);
   wire rd_status      = (ARADDR == `CFG_ADDR_STATUS);
   wire rd_setup       = (ARADDR == `CFG_ADDR_SETUP);
   wire rd_tx          = (ARADDR == `CFG_ADDR_TX_RAW);
   wire rd_rx          = (ARADDR == `CFG_ADDR_RX_DATA);
   wire rd_hit         = rd_ctrl | rd_status | rd_setup | rd_tx | rd_rx;
   wire [31:0] rd_mux  = rd_ctrl   ? {31'h0, gate_en_ff} :
                         rd_status ? status_w :
                         rd_setup  ? setup_ff :
                         rd_tx     ? tx_raw_ff :
                         rd_rx     ? rx_w : 32'h0;

   // ------------------------------------------------------------------
   // serial datapath
   // ------------------------------------------------------------------
   logic [CW-1:0]        bit_cnt_ff;
   logic [WORD_BITS-1:0] rx_sh_ff;
   logic [WORD_BITS-1:0] tx_sh_ff;
   wire uni            = setup_ff[`CFG_SETUP_UNI_BIT];
   wire [WORD_BITS-1:0] raw = tx_raw_ff[WORD_BITS-1:0];
   wire [WORD_BITS-1:0] coded = uni ? raw :
                                {~raw[WORD_BITS-1], raw[WORD_BITS-2:0]};
   wire word_done      = sel & sclk_rise &
                         (bit_cnt_ff == CW'(WORD_BITS - 1));

   always_ff @(posedge MCLK)
   begin
      if (!RST_B)
      begin
         sclk_prev_ff <= 1'b0;
         cs_prev_ff   <= 1'b1;
         xin_prev_ff  <= 1'b0;
         state_ff     <= adc_port_pkg::ST_POR_WAIT;
         por_cnt_ff   <= 11'h0;
      end
      else if (CE)
      begin
         sclk_prev_ff <= sclk_q;
         cs_prev_ff   <= cs_q;
         xin_prev_ff  <= xin_q;
         if (por_busy && xin_rise)
            por_cnt_ff <= por_cnt_ff + 11'h1;
         if (por_busy && por_last)
            state_ff <= adc_port_pkg::ST_RUN;
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (!RST_B || (CE && !sel))
      begin
         bit_cnt_ff <= '0;
      end
      else if (CE && sclk_rise)
      begin
         bit_cnt_ff <= word_done ? '0 : bit_cnt_ff + CW'(1);
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (!RST_B || (CE && por_busy))
      begin
         rx_sh_ff        <= '0;
         tx_sh_ff        <= '0;
         SERIAL_OUT_PIN  <= 1'b0;
         SERIAL_OUT_OE_B <= 1'b1;
      end
      else if (CE)
      begin
         SERIAL_OUT_OE_B <= cs_q;
         if (sel && sclk_rise)
            rx_sh_ff <= {rx_sh_ff[WORD_BITS-2:0], sdi_q};
         if (cs_fall)
         begin
            tx_sh_ff       <= coded;
            SERIAL_OUT_PIN <= coded[WORD_BITS-1];
         end
         else if (sel && sclk_fall)
         begin
            tx_sh_ff       <= {tx_sh_ff[WORD_BITS-2:0], 1'b0};
            SERIAL_OUT_PIN <= tx_sh_ff[WORD_BITS-2];
         end
      end
   end

   // ------------------------------------------------------------------
   // AXI4-Lite slave and registers
   // ------------------------------------------------------------------
   always_ff @(posedge MCLK)
   begin
      if (!RST_B)
      begin
         AWREADY    <= 1'b1;
         WREADY     <= 1'b1;
         BVALID     <= 1'b0;
         BRESP      <= `CFG_RESP_OKAY;
         ARREADY    <= 1'b1;
         RVALID     <= 1'b0;
         RDATA      <= 32'h0;
         RRESP      <= `CFG_RESP_OKAY;
         awaddr_ff  <= 8'h0;
         wdata_ff   <= 32'h0;
         wstrb_ff   <= 4'h0;
         gate_en_ff <= `CFG_CTRL_RST;
         setup_ff   <= `CFG_SETUP_RST;
         tx_raw_ff  <= 32'h0;
         rv_ff      <= 1'b0;
         rxv_ff     <= 1'b0;
         rx_word_ff <= '0;
      end
      else if (CE)
      begin
         if (AWVALID && AWREADY)
         begin
            awaddr_ff <= AWADDR;
            AWREADY   <= 1'b0;
         end
         if (WVALID && WREADY)
         begin
            wdata_ff <= WDATA;
            wstrb_ff <= WSTRB;
            WREADY   <= 1'b0;
         end
         if (do_write)
         begin
            BVALID <= 1'b1;
            BRESP  <= wr_hit ? `CFG_RESP_OKAY : `CFG_RESP_SLVERR;
         end
         if (BVALID && BREADY)
         begin
            BVALID  <= 1'b0;
            AWREADY <= 1'b1;
            WREADY  <= 1'b1;
         end
         if (ar_take)
         begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b1;
            RDATA   <= rd_mux;
            RRESP   <= rd_hit ? `CFG_RESP_OKAY : `CFG_RESP_SLVERR;
         end
         if (RVALID && RREADY)
         begin
            RVALID  <= 1'b0;
            ARREADY <= 1'b1;
         end
         if (wr_ctrl && wstrb_ff[0])
            gate_en_ff <= wdata_ff[`CFG_CTRL_GATE_BIT];
         if (wr_setup)
            setup_ff <= (setup_ff & ~bmask) | (wdata_ff & bmask);
         if (wr_tx)
            tx_raw_ff <= (tx_raw_ff & ~bmask) | (wdata_ff & bmask);
         // set wins over a clear in the same cycle
         // hold marks a valid reset
         rv_ff  <= por_busy | (rv_ff & ~clr_rv);
         rxv_ff <= word_done | (rxv_ff & ~clr_rxv);
         if (word_done)
            rx_word_ff <= {rx_sh_ff[WORD_BITS-2:0], sdi_q};
      end
   end

   // ------------------------------------------------------------------
   // logic outputs and crystal gate
   // ------------------------------------------------------------------
   always_ff @(posedge MCLK)
   begin
      if (!RST_B)
      begin
         LOGIC_OUT_LOW  <= 1'b0;
         LOGIC_OUT_HIGH <= 1'b0;
         CRYSTAL_OUTPUT <= 1'b0;
      end
      else if (CE)
      begin
         LOGIC_OUT_LOW  <= setup_ff[`CFG_SETUP_LO_BIT];
         LOGIC_OUT_HIGH <= setup_ff[`CFG_SETUP_HI_BIT];
         // gate off leaves an outside clock alone
         CRYSTAL_OUTPUT <= gate_en_ff & ~xin_q;
      end
   end

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_B);

   property p_idle_ignored;
      CE && cs_q |=> bit_cnt_ff == '0;
   endproperty
   a_idle_ignored: assert property (p_idle_ignored)
      else $error("sclk counted while deselected");

   property p_hiz;
      CE && cs_q |=> SERIAL_OUT_OE_B;
   endproperty
   a_hiz: assert property (p_hiz)
      else $error("serial out driven while deselected");

   property p_take_bit;
      CE && sel && sclk_rise |=> rx_sh_ff[0] == $past(sdi_q);
   endproperty
   a_take_bit: assert property (p_take_bit)
      else $error("input bit not taken");

   // the release edge still runs the reset branch, so it is skipped
   property p_logic_out;
      RST_B && CE |=> LOGIC_OUT_LOW == $past(setup_ff[`CFG_SETUP_LO_BIT])
         && LOGIC_OUT_HIGH == $past(setup_ff[`CFG_SETUP_HI_BIT]);
   endproperty
   a_logic_out: assert property (p_logic_out)
      else $error("logic outputs do not follow setup");

   property p_gate;
      RST_B && CE && gate_en_ff |=> CRYSTAL_OUTPUT == !$past(xin_q);
   endproperty
   a_gate: assert property (p_gate)
      else $error("crystal gate wrong");

   property p_unipolar;
      CE && cs_fall && !por_busy && uni |=> tx_sh_ff == $past(raw);
   endproperty
   a_unipolar: assert property (p_unipolar)
      else $error("unipolar word altered");

   property p_bipolar;
      CE && cs_fall && !por_busy && !uni
         |=> SERIAL_OUT_PIN == !$past(raw[WORD_BITS-1]);
   endproperty
   a_bipolar: assert property (p_bipolar)
      else $error("bipolar msb not inverted");

   property p_por_flag;
      RST_B && CE && por_busy
         |=> rv_ff && SERIAL_OUT_OE_B && bit_cnt_ff == '0;
   endproperty
   a_por_flag: assert property (p_por_flag)
      else $error("port not held in reset");

   property p_por_len;
      por_cnt_ff <= `CFG_POR_OSC_CYCLES;
   endproperty
   a_por_len: assert property (p_por_len)
      else $error("power-on count overran");

   property p_out_edge;
      CE && !cs_fall && !(sel && sclk_fall) && !por_busy
         |=> $stable(SERIAL_OUT_PIN);
   endproperty
   a_out_edge: assert property (p_out_edge)
      else $error("serial out moved off the falling edge");

   c_word: cover property (CE && word_done);
   c_write: cover property (BVALID && BREADY);
   c_por_done: cover property (CE && por_busy ##1 !por_busy);
   c_bipolar: cover property (CE && cs_fall && !por_busy && !uni);
endmodule

// [hdl/adc_port_cfg.svh]
// Purpose: offsets, field positions, reset values and counts of adc_port
// Assumes: AXI4-Lite byte addresses, 32-bit data
// Notes:   definitions only
`ifndef ADC_PORT_CFG_SVH
`define ADC_PORT_CFG_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define CFG_ADDR_CTRL     8'h00
`define CFG_ADDR_STATUS   8'h04
`define CFG_ADDR_SETUP    8'h08
`define CFG_ADDR_TX_RAW   8'h0c
`define CFG_ADDR_RX_DATA  8'h10

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CFG_CTRL_GATE_BIT 0
`define CFG_ST_RV_BIT     0
`define CFG_ST_RXV_BIT    1
`define CFG_ST_BUSY_BIT   2
`define CFG_ST_SEL_BIT    3
`define CFG_SETUP_UNI_BIT 0
`define CFG_SETUP_LO_BIT  22
`define CFG_SETUP_HI_BIT  23

// ----------------------------------------------------------------------
// reset values, answers, counts
// ----------------------------------------------------------------------
`define CFG_CTRL_RST      1'h1
`define CFG_SETUP_RST     32'h0000_0000
`define CFG_RESP_OKAY     2'h0
`define CFG_RESP_SLVERR   2'h2
`define CFG_POR_OSC_CYCLES 11'h7d6

`endif

// [hdl/adc_port_pkg.sv]
// Purpose: shared types of adc_port
// Assumes: nothing
// Notes:   one-hot state codes
package adc_port_pkg;
   typedef enum logic [1:0] {
      ST_POR_WAIT = 2'b01,
      ST_RUN      = 2'b10
   } por_state_t;
endpackage

// [hdl/pin_sync.sv]
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs asynchronous to clk
// Notes:   q follows only when stages two and three agree
module pin_sync #(
   parameter int             W    = 1,
   parameter logic [W-1:0]   INIT = '0
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   wire  [W-1:0] agree = ~(s2_ff ^ s3_ff);
   wire  [W-1:0] nxt_q = (agree & s3_ff) | (~agree & q);

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         s1_ff <= INIT;
         s2_ff <= INIT;
         s3_ff <= INIT;
         q     <= INIT;
      end
      else if (ce)
      begin
         s1_ff <= d;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         q     <= nxt_q;
      end
   end
endmodule

// [verification/serial_host.sv]
// Purpose: host model driving the serial port of adc_port
// Assumes: link clock period 160 ns, held low outside frames except while stray clocks run
// Notes:   released data line shows the inverse of its last value
module serial_host (
   output logic      cs_b,
   output logic      sclk,
   output logic      serial_in_pin,
   input  wire logic serial_out_pin,
   input  wire logic sdo_oe_b
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF = 80;

   initial
   begin
      cs_b = 1'b1;
      sclk = 1'b0;
      serial_in_pin  = 1'b0;
   end

   // ------------------------------------------------------------
   // one word each way, msb first
   // ------------------------------------------------------------
   task automatic frame(input logic [23:0] tx, output logic [23:0] rx);
      // keep every pin move off the bench clock edge
      #2;
      cs_b = 1'b0;
      #HALF;
      for (int i = 23; i >= 0; i--)
      begin
         serial_in_pin = tx[i];
         #HALF;
         // one bit a period, taken on rise
         sclk = 1'b1;
         rx[i] = (sdo_oe_b === 1'b0) ? serial_out_pin : 1'bx;
         #HALF;
         sclk = 1'b0;
      end
      #HALF;
      cs_b = 1'b1;
      serial_in_pin  = ~serial_in_pin;
   endtask

   // stray clocks while deselected; the port must not count them
   task automatic stray(input int n);
      #2;
      repeat (n)
      begin
         #HALF sclk = 1'b1;
         #HALF sclk = 1'b0;
      end
   endtask
endmodule

// [verification/testbench.sv]
// Purpose: self-checking bench of adc_port
// Assumes: seed 67, crystal toggling every 20 ns, link clock 160 ns
// Notes:   bus tasks speak AXI4-Lite, one write or read at a time
`include "adc_port_cfg.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        MCLK, RST_B, CE, AWVALID, WVALID, BREADY;
   logic        ARVALID, RREADY, CRYSTAL_INPUT;
   logic [7:0]  AWADDR, ARADDR;
   logic [31:0] WDATA;
   logic [3:0]  WSTRB;
   wire         AWREADY, WREADY, BVALID, ARREADY, RVALID, CS_B, SCLK;
   wire         SERIAL_IN_PIN, SERIAL_OUT_PIN, SERIAL_OUT_OE_B;
   wire         LOGIC_OUT_LOW, LOGIC_OUT_HIGH, CRYSTAL_OUTPUT;
   wire [1:0]   BRESP, RRESP;
   wire [31:0]  RDATA;
   int          err_total;
   int          compares;

   adc_port #(.WORD_BITS(24)) dut (.MCLK, .RST_B, .CE, .AWADDR, .AWVALID,
      .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY,
      .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .CS_B,
      .SCLK, .SERIAL_IN_PIN, .SERIAL_OUT_PIN, .SERIAL_OUT_OE_B,
      .LOGIC_OUT_LOW, .LOGIC_OUT_HIGH, .CRYSTAL_INPUT, .CRYSTAL_OUTPUT);

   serial_host host (.cs_b(CS_B), .sclk(SCLK), .serial_in_pin(SERIAL_IN_PIN),
      .serial_out_pin(SERIAL_OUT_PIN), .sdo_oe_b(SERIAL_OUT_OE_B));

   always #5 MCLK = ~MCLK;
   always #20 CRYSTAL_INPUT = ~CRYSTAL_INPUT;

   // ------------------------------------------------------------
   // checking and closing
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      compares++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
                  got, exp);
      end
   endtask

   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic timeout(input string what);
      err_total++;
      $display("CHECK FAILED at %0t: %s timed out", $time, what);
      summarize();
   endtask

   function automatic logic [23:0] coded(input logic [23:0] w,
                                         input logic uni);
      return uni ? w : {~w[23], w[22:0]};
   endfunction

   // ------------------------------------------------------------
   // bus master
   // ------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge MCLK);
      AWADDR  <= a;
      WDATA   <= d;
      AWVALID <= 1'b1;
      WVALID  <= 1'b1;
      BREADY  <= 1'b1;
      for (n = 0; n < 60; n++)
      begin
         @(posedge MCLK);
         if (AWVALID && AWREADY === 1'b1)
            AWVALID <= 1'b0;
         if (WVALID && WREADY === 1'b1)
            WVALID <= 1'b0;
         if (BVALID === 1'b1)
         begin
            chk({30'h0, BRESP}, {30'h0, `CFG_RESP_OKAY}, "bresp");
            BREADY <= 1'b0;
            break;
         end
      end
      if (n == 60)
         timeout("write");
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      int n;
      n = 0;
      @(posedge MCLK);
      ARADDR  <= a;
      ARVALID <= 1'b1;
      RREADY  <= 1'b1;
      for (n = 0; n < 60; n++)
      begin
         @(posedge MCLK);
         if (ARVALID && ARREADY === 1'b1)
            ARVALID <= 1'b0;
         if (RVALID === 1'b1)
         begin
            d = RDATA;
            r = RRESP;
            RREADY <= 1'b0;
            break;
         end
      end
      if (n == 60)
         timeout("read");
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      logic [31:0] d;
      logic [31:0] s;
      logic [1:0]  r;
      logic [23:0] tx;
      logic [23:0] hw;
      logic [23:0] got;
      int          n;
      bit          seen;
      {MCLK, RST_B, CE, CRYSTAL_INPUT} = 4'h2;
      {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h0;
      {AWADDR, ARADDR, WDATA, WSTRB} = {16'h0, 32'h0, 4'hf};
      err_total = 0;
      compares = 0;
      d = $urandom(67);
      repeat (8) @(posedge MCLK);
      RST_B <= 1'b1;

      rd(`CFG_ADDR_CTRL, d, r);
      chk(d, 32'h1, "ctrl reset");
      rd(`CFG_ADDR_SETUP, d, r);
      chk(d, `CFG_SETUP_RST, "setup reset");
      rd(8'h20, d, r);
      chk({30'h0, r}, {30'h0, `CFG_RESP_SLVERR}, "unmapped");
      rd(`CFG_ADDR_STATUS, d, r);
      chk(d[2:0], 3'h5, "hold flags");
      host.frame(24'ha5a5a5, got);
      chk({8'h0, got}, {8'h0, {24{1'bx}}}, "held out");
      rd(`CFG_ADDR_STATUS, d, r);
      chk(d[1], 1'b0, "held rx");
      n = 0;
      while (d[2] !== 1'b0)
      begin
         n++;
         if (n > 600)
            timeout("power-on hold");
         repeat (20) @(posedge MCLK);
         rd(`CFG_ADDR_STATUS, d, r);
      end
      chk(d[0], 1'b1, "rv kept");
      wr(`CFG_ADDR_STATUS, 32'h1);
      rd(`CFG_ADDR_STATUS, d, r);
      chk(d[0], 1'b0, "rv cleared");
      $display("test reset done");

      for (int i = 0; i < 4; i++)
      begin
         d = $urandom;
         d[23:22] = i[1:0];
         wr(`CFG_ADDR_SETUP, d);
         repeat (2) @(posedge MCLK);
         chk({LOGIC_OUT_HIGH, LOGIC_OUT_LOW}, i, "logic outs");
      end
      // byte lane 2 only: clears bits 23:16, keeps the rest
      WSTRB <= 4'h4;
      wr(`CFG_ADDR_SETUP, 32'h0);
      WSTRB <= 4'hf;
      rd(`CFG_ADDR_SETUP, s, r);
      chk(s, d & 32'hff00_ffff, "byte mask");
      chk({LOGIC_OUT_HIGH, LOGIC_OUT_LOW}, 32'h0, "outs off");
      $display("test logic outputs done");

      for (int k = 0; k < 6; k++)
      begin
         tx = (k < 2) ? {24{k[0]}} : 24'($urandom);
         hw = (k < 2) ? ~tx : 24'($urandom);
         wr(`CFG_ADDR_TX_RAW, {8'h0, tx});
         s = $urandom;
         s[0] = k[0];
         wr(`CFG_ADDR_SETUP, s);
         if (k == 2)
            host.stray(3);
         host.frame(hw, got);
         chk(got, coded(tx, k[0]), "out word");
         rd(`CFG_ADDR_RX_DATA, d, r);
         chk(d, {8'h0, hw}, "rx word");
         rd(`CFG_ADDR_STATUS, d, r);
         chk(d[1], 1'b1, "rx valid");
         wr(`CFG_ADDR_STATUS, 32'h2);
         chk(SERIAL_OUT_OE_B, 1'b1, "released");
      end
      $display("test frames done");

      wr(`CFG_ADDR_CTRL, 32'h0);
      repeat (10) @(posedge MCLK);
      chk(CRYSTAL_OUTPUT, 1'b0, "gate off");
      wr(`CFG_ADDR_CTRL, 32'h1);
      seen = 0;
      repeat (20)
      begin
         @(posedge MCLK);
         seen |= (CRYSTAL_OUTPUT === 1'b1);
      end
      chk(seen, 1'b1, "gate runs");
      $display("test clock gate done");
      summarize();
   end
endmodule
